// [rtl/sbm_pkg.sv]
// package for the system bus master port: constants and carrier structs
package sbm_pkg;
   localparam int unsigned ADDR_W          = 23;
   localparam int unsigned SEL_W           = 6;
   localparam int unsigned STAT_W          = 3;
   localparam int unsigned RST_DLY_CYC     = 10;
   // bus cycle status codes, low three bits
   localparam logic [2:0]  STAT_IDLE       = 3'h0;
   localparam logic [2:0]  STAT_REQ        = 3'h1;
   localparam logic [2:0]  STAT_READ       = 3'h2;
   localparam logic [2:0]  STAT_WRITE      = 3'h3;
   localparam logic [2:0]  STAT_RESET      = 3'h7;

   typedef enum logic [2:0] {
      SBM_IDLE,
      SBM_REQ,
      SBM_OWN,
      SBM_ADDR,
      SBM_DATA,
      SBM_REL
   } sbm_state_type;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
   } sbm_req_type;

   typedef struct packed {
      sbm_state_type     st;
      logic              in_reset;
      logic [RST_DLY_CYC-1:0] rst_sh;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic              strobe_act;
      logic              own;
      logic              grant_acknowledge_out_act;
      logic [2:0]        status;
      logic              irq;
      logic              done;
   } sbm_regs_type;
endpackage : sbm_pkg

// [rtl/sbm_master_port.sv]
// system bus master port: arbitration, address strobe, direction, interrupt pin
`timescale 1ns/10ps
module sbm_master_port (
   input  wire logic                      ref_clk,
   input  wire logic                      nrst,
   input  wire logic                      bus_convention_strap,
   input  wire sbm_pkg::sbm_req_type      dma_req,
   output logic                           dma_req_ready,
   output logic                           dma_done,
   input  wire logic [15:0]               irq_status,
   input  wire logic [15:0]               irq_mask,
   input  wire logic [sbm_pkg::SEL_W-1:0] register_select_lines,
   output logic [sbm_pkg::SEL_W-1:0]      reg_select_out,
   output logic [sbm_pkg::ADDR_W-1:0]     dma_address_out,
   output logic                           dma_address_oe,
   output logic                           addr_strobe_o,
   output logic                           addr_strobe_oe,
   input  wire logic                      address_strobe_big_i,
   output logic                           dir_o,
   output logic                           dir_oe,
   output logic                           irq_o,
   output logic                           irq_oe,
   output logic [sbm_pkg::STAT_W-1:0]     bus_cycle_status,
   output logic                           request_o,
   output logic                           request_oe,
   input  wire logic                      grant_in_big,
   input  wire logic                      grant_in_little,
   output logic                           grant_acknowledge_out,
   output logic                           grant_acknowledge_oe,
   input  wire logic                      grant_acknowledge_in,
   input  wire logic                      slave_transfer_ack_lo,
   input  wire logic                      slave_transfer_ack_hi,
   output logic                           in_reset_o
);
   sbm_pkg::sbm_regs_type r_ff;
   sbm_pkg::sbm_regs_type nxt_r;
   logic                  big;
   logic                  granted;
   logic                  bus_free;
   logic                  chk_grant;
   logic                  chk_strobe;
   logic                  chk_slaves;
   logic                  chk_master;
   logic [15:0]           irq_live;

   assign big = bus_convention_strap;

   // per-source gate: a pending source counts only while its mask enables it
   for (genvar g = 0; g < 16; g++) begin : g_irq_gate
      assign irq_live[g] = irq_status[g] && irq_mask[g];
   end

   // register select is just passed to the register file; latched there
   assign reg_select_out = register_select_lines;
   // four checks before taking the bus in big mode; strobes are active low
   // each check named, so a stuck wire shows which one holds us off
   assign chk_grant  = !grant_in_big;
   assign chk_strobe = address_strobe_big_i;
   assign chk_slaves = slave_transfer_ack_lo && slave_transfer_ack_hi;
   assign chk_master = grant_acknowledge_in;
   assign bus_free   = chk_grant && chk_strobe && chk_slaves && chk_master;
   assign granted = big ? r_ff.grant_acknowledge_out_act : grant_in_little;

   always_comb begin
      nxt_r = r_ff;
      nxt_r.done = 1'b0;
      nxt_r.irq = |irq_live;
      if (r_ff.in_reset) begin
         nxt_r.st = sbm_pkg::SBM_IDLE;
         nxt_r.own = 1'b0;
         nxt_r.grant_acknowledge_out_act = 1'b0;
         nxt_r.strobe_act = 1'b0;
         nxt_r.status = sbm_pkg::STAT_RESET;
         nxt_r.in_reset = 1'b0;
      end else begin
         case (r_ff.st)
            sbm_pkg::SBM_IDLE: begin
               nxt_r.status = sbm_pkg::STAT_IDLE;
               if (dma_req.valid) begin
                  nxt_r.write = dma_req.write;
                  nxt_r.addr = dma_req.addr;
                  nxt_r.st = sbm_pkg::SBM_REQ;
                  nxt_r.status = sbm_pkg::STAT_REQ;
               end
            end
            sbm_pkg::SBM_REQ: begin
               if (big && bus_free)
                  nxt_r.grant_acknowledge_out_act = 1'b1;
               if (granted) begin
                  nxt_r.own = 1'b1;
                  // status turns to read or write as soon as the pins are ours
                  nxt_r.status = r_ff.write ? sbm_pkg::STAT_WRITE : sbm_pkg::STAT_READ;
                  nxt_r.st = sbm_pkg::SBM_OWN;
               end
            end
            sbm_pkg::SBM_OWN: begin
               // two cycles of bus with strobe idle (here and in SBM_ADDR) before the address edge
               nxt_r.status = r_ff.write ? sbm_pkg::STAT_WRITE : sbm_pkg::STAT_READ;
               nxt_r.st = sbm_pkg::SBM_ADDR;
            end
            sbm_pkg::SBM_ADDR: begin
               nxt_r.strobe_act = 1'b1;
               nxt_r.st = sbm_pkg::SBM_DATA;
            end
            sbm_pkg::SBM_DATA: begin
               // slaves ack low; end the cycle when any acknowledges
               if (!slave_transfer_ack_lo || !slave_transfer_ack_hi) begin
                  nxt_r.strobe_act = 1'b0;
                  nxt_r.done = 1'b1;
                  nxt_r.st = sbm_pkg::SBM_REL;
               end
            end
            sbm_pkg::SBM_REL: begin
               nxt_r.own = 1'b0;
               nxt_r.grant_acknowledge_out_act = 1'b0;
               nxt_r.status = sbm_pkg::STAT_IDLE;
               nxt_r.st = sbm_pkg::SBM_IDLE;
            end
            default: nxt_r.st = sbm_pkg::SBM_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         // reset held low: shift in ones, the tenth edge enters reset state
         // a shifter, not a counter, so an unknown power-up value still settles
         if (r_ff.rst_sh[sbm_pkg::RST_DLY_CYC-2]) begin
            r_ff          <= '0;
            r_ff.rst_sh   <= '1;
            r_ff.in_reset <= 1'b1;
            r_ff.status   <= sbm_pkg::STAT_RESET;
         end else begin
            r_ff        <= nxt_r;
            r_ff.rst_sh <= {r_ff.rst_sh[sbm_pkg::RST_DLY_CYC-2:0], 1'b1};
         end
      end else begin
         r_ff        <= nxt_r;
         r_ff.rst_sh <= '0;
      end
   end

   // address, strobe and direction float unless we own the bus
   always_comb begin
      dma_address_out = r_ff.addr;
      dma_address_oe  = r_ff.own;
      addr_strobe_oe  = r_ff.own;
      dir_oe          = r_ff.own;
      if (big) begin
         // strobe active low: falls on valid address, rises at cycle end
         addr_strobe_o         = !r_ff.strobe_act;
         dir_o                 = !r_ff.write;
         // open drain interrupt: drive low only, else release
         irq_o                 = 1'b0;
         irq_oe                = r_ff.irq;
         request_o             = 1'b0;
         request_oe            = (r_ff.st == sbm_pkg::SBM_REQ);
         grant_acknowledge_out = 1'b0;
         grant_acknowledge_oe  = r_ff.grant_acknowledge_out_act;
      end else begin
         addr_strobe_o         = r_ff.strobe_act;
         dir_o                 = r_ff.write;
         irq_o                 = r_ff.irq;
         irq_oe                = 1'b1;
         // hold stays up through the release state, so the bus is not lost early
         request_o             = (r_ff.st != sbm_pkg::SBM_IDLE);
         request_oe            = 1'b1;
         // grant acknowledge has no use in the little convention
         grant_acknowledge_out = 1'b0;
         grant_acknowledge_oe  = 1'b0;
      end
   end
   assign bus_cycle_status = r_ff.status;
   assign dma_req_ready = (r_ff.st == sbm_pkg::SBM_IDLE) && !r_ff.in_reset;
   assign dma_done = r_ff.done;
   assign in_reset_o = r_ff.in_reset;
endmodule : sbm_master_port

// [verification/sbm_master_port_properties.sv]
// assertions on the pins of the system bus master port
`timescale 1ns/10ps
module sbm_master_port_properties (
   input wire logic        ref_clk, nrst, bus_convention_strap, dma_req_ready, dma_address_oe,
   input wire logic        addr_strobe_o, addr_strobe_oe, dir_o, dir_oe, irq_o, irq_oe,
   input wire logic [15:0] irq_status, irq_mask,
   input wire logic [2:0]  bus_cycle_status,
   input wire logic        request_o, request_oe, grant_in_big, grant_acknowledge_oe,
   input wire logic        grant_acknowledge_in, address_strobe_big_i,
   input wire logic        slave_transfer_ack_lo, slave_transfer_ack_hi
);
   logic bus_free;
   // all four takeover checks in one term, so $past sees a plain signal
   assign bus_free = !grant_in_big && address_strobe_big_i && slave_transfer_ack_lo
                     && slave_transfer_ack_hi && grant_acknowledge_in;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_oe_together:
      assert property (dir_oe == dma_address_oe && addr_strobe_oe == dma_address_oe)
      else $error("pin enables split");
   a_read_dir:
      assert property (dir_oe && bus_cycle_status == 3'h2 |-> dir_o == bus_convention_strap)
      else $error("read direction wrong");
   a_write_dir:
      assert property (dir_oe && bus_cycle_status == 3'h3 |-> dir_o != bus_convention_strap)
      else $error("write direction wrong");
   a_irq_masked:
      assert property (!(|(irq_status & irq_mask)) |=> (bus_convention_strap ? !irq_oe : !irq_o))
      else $error("masked interrupt seen");
   a_irq_pins:
      assert property (bus_convention_strap ? !irq_o : irq_oe) else $error("interrupt pin style");
   a_req_big:
      assert property (bus_convention_strap && request_oe |-> !request_o && bus_cycle_status == 3'h1)
      else $error("bus request wrong");
   a_hold_little:
      assert property (!bus_convention_strap && dma_req_ready |-> request_oe && !request_o)
      else $error("hold request wrong");
   a_gack_checks:
      assert property ($rose(grant_acknowledge_oe) |-> bus_convention_strap && $past(bus_free))
      else $error("grant ack too early");
   cover property ($rose(grant_acknowledge_oe));
   cover property (addr_strobe_oe && addr_strobe_o && !bus_convention_strap);
   cover property (irq_oe && bus_convention_strap);
endmodule : sbm_master_port_properties
bind sbm_master_port sbm_master_port_properties i_props (.*);

// [verification/sbm_far_model.sv]
// far side: bus arbiter and memory slave, answering after lat cycles
`timescale 1ns/10ps
module sbm_far_model (
   input  wire logic       ref_clk, strap, req_o, req_oe, stb_o, stb_oe, own,
   input  wire logic [1:0] lat,
   output logic            grant_big, grant_little, ack_lo, ack_hi
);
   logic [1:0] gc, ac;
   logic       want, stb, gnt, ack;
   assign want = strap ? req_oe && !req_o : req_o;
   assign stb = stb_oe && (stb_o != strap);
   // grant kept while owner, so ownership is never pulled mid-cycle
   assign gnt = (want || own) && gc == lat;
   assign ack = stb && ac == lat;
   always_ff @(posedge ref_clk) begin
      gc <= (want || own) ? gc + 2'(gc != lat) : 2'h0;
      ac <= stb ? ac + 2'(ac != lat) : 2'h0;
   end
   assign grant_big = !(gnt && strap);
   assign grant_little = gnt && !strap;
   // acks released to the pull-up level between cycles
   assign ack_lo = !ack;
   assign ack_hi = !ack;
endmodule : sbm_far_model

// [verification/system_bus_master_port_test.sv]
// self-checking bench for the system bus master port
`timescale 1ns/10ps
module system_bus_master_port_test;
   logic ref_clk = 1'b0, nrst, bus_convention_strap, dma_req_ready, dma_done, dma_address_oe;
   logic addr_strobe_o, addr_strobe_oe, address_strobe_big_i, dir_o, dir_oe, irq_o, irq_oe;
   logic request_o, request_oe, grant_in_big, grant_in_little, grant_acknowledge_out;
   logic grant_acknowledge_oe, grant_acknowledge_in, slave_transfer_ack_lo, slave_transfer_ack_hi;
   logic in_reset_o;
   logic [15:0] irq_status, irq_mask;
   logic [5:0] register_select_lines, reg_select_out;
   logic [22:0] dma_address_out;
   logic [2:0] bus_cycle_status, ev;
   logic [1:0] lat;
   sbm_pkg::sbm_req_type dma_req;
   int error_cnt = 0, num_checks = 0, seed;
   assign ev = {dma_done, dma_address_oe, dma_req_ready};
   // open-drain wires float to the pull-up level
   assign address_strobe_big_i = addr_strobe_oe ? addr_strobe_o : 1'b1;
   assign grant_acknowledge_in = grant_acknowledge_oe ? grant_acknowledge_out : 1'b1;
   always #2.5 ref_clk = ~ref_clk;
   sbm_master_port i_dut (.*);
   sbm_far_model i_far (.ref_clk(ref_clk), .strap(bus_convention_strap), .req_o(request_o),
      .req_oe(request_oe), .stb_o(addr_strobe_o), .stb_oe(addr_strobe_oe), .own(dma_address_oe),
      .lat(lat), .grant_big(grant_in_big), .grant_little(grant_in_little),
      .ack_lo(slave_transfer_ack_lo), .ack_hi(slave_transfer_ack_hi));
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int k);
      int n;
      n = 0;
      do begin @(negedge ref_clk); n++; end while (ev[k] !== 1'b1 && n < 60);
      if (ev[k] !== 1'b1) begin error_cnt++; end_sim(); end
   endtask : wt
   function automatic logic [1:0] exp_irq(input logic big, input logic pend);
      return big ? {1'b0, pend} : {pend, 1'b1};
   endfunction : exp_irq
   task automatic xfer(input logic wr, input logic [22:0] ad);
      @(posedge ref_clk);
      lat <= 2'($random(seed));
      irq_status <= 16'($random(seed));
      irq_mask <= 16'($random(seed));
      register_select_lines <= 6'($random(seed));
      wt(0);
      @(posedge ref_clk) dma_req <= '{1'b1, wr, ad};
      @(posedge ref_clk) dma_req.valid <= 1'b0;
      wt(1);
      chk(dma_address_out, ad);
      chk(dir_o, bus_convention_strap ? !wr : wr);
      chk(bus_cycle_status, {2'h1, wr});
      wt(2);
      chk(reg_select_out, register_select_lines);
      chk({irq_o, irq_oe}, exp_irq(bus_convention_strap, |(irq_status & irq_mask)));
   endtask : xfer
   task automatic rst(input logic big, input logic early);
      @(posedge ref_clk);
      nrst <= 1'b0;
      bus_convention_strap <= big;
      repeat (9) @(posedge ref_clk);
      @(negedge ref_clk);
      if (early) chk(in_reset_o, 0);
      @(negedge ref_clk);
      chk(in_reset_o, 1);
      @(posedge ref_clk) nrst <= 1'b1;
   endtask : rst
   initial begin
      seed = 32'ha44a;
      nrst = 1'b0;
      bus_convention_strap = 1'b1;
      dma_req = '0;
      lat = 2'h0;
      irq_status = 16'h0;
      irq_mask = 16'h0;
      register_select_lines = 6'h0;
      for (int m = 0; m < 2; m++) begin
         rst(m == 0, m == 1);
         xfer(1'b0, 23'h7fffff);
         xfer(1'b1, 23'h000000);
         repeat (20) xfer(1'($random(seed)), 23'($random(seed)));
      end
      end_sim();
   end
endmodule : system_bus_master_port_test
